// ===== src/mseq_axil.sv
// axi4-lite slave holding the sequencer control and status words
`timescale 1ns/1ps
`include "mseq_params.svh"
module mseq_axil (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // write channels
  input wire logic [`MSEQ_AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read channels
  input wire logic [`MSEQ_AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // sequencer side
  output logic [`MSEQ_AW-1:0] loopLoadValue,
  input wire logic [`MSEQ_AW-1:0] statusY,
  input wire logic [`MSEQ_AW-1:0] statusLoop,
  input wire logic [`MSEQ_PW-1:0] statusSp,
  input wire logic [`MSEQ_PW-1:0] statusRp
);
  logic [`MSEQ_AXI_AW-1:0] awAddr_ff;
  logic awHave_ff;
  logic [31:0] wData_ff;
  logic [3:0] wStrb_ff;
  logic wHave_ff;
  logic [15:0] loopVal_ff;

  assign loopLoadValue = loopVal_ff;

  // readies drop on acceptance and come back with the response handshake
  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_arready <= 1'b1;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      awHave_ff <= 1'b0;
      wHave_ff <= 1'b0;
      awAddr_ff <= '0;
      wData_ff <= '0;
      wStrb_ff <= '0;
    end else if (awHave_ff && wHave_ff) begin
      awHave_ff <= 1'b0;
      wHave_ff <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end
    end
  end

  // write commit and response
  always_ff @(posedge clk) begin
    if (reset) begin
      loopVal_ff <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MSEQ_RESP_OK;
    end else if (awHave_ff && wHave_ff) begin
      s_axi_bvalid <= 1'b1;
      if (awAddr_ff == `MSEQ_REG_LOOP) begin
        s_axi_bresp <= `MSEQ_RESP_OK;
        if (wStrb_ff[0]) loopVal_ff[7:0] <= wData_ff[7:0];
        if (wStrb_ff[1]) loopVal_ff[15:8] <= wData_ff[15:8];
      end else if (awAddr_ff == `MSEQ_REG_CTRL || awAddr_ff == `MSEQ_REG_STAT
          || awAddr_ff == `MSEQ_REG_PTR) begin
        s_axi_bresp <= `MSEQ_RESP_OK;
      end else begin
        s_axi_bresp <= `MSEQ_RESP_ERR;
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `MSEQ_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `MSEQ_RESP_OK;
      unique case (s_axi_araddr)
        `MSEQ_REG_CTRL: s_axi_rdata <= {16'h0000, loopVal_ff};
        `MSEQ_REG_STAT: s_axi_rdata <= {16'h0000, statusY};
        `MSEQ_REG_LOOP: s_axi_rdata <= {16'h0000, statusLoop};
        `MSEQ_REG_PTR: s_axi_rdata <= {24'h000000, statusRp, statusSp};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= `MSEQ_RESP_ERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ===== src/mseq_core.sv
// microsequencer next-address, loop counter and stack logic
`timescale 1ns/1ps
`include "mseq_params.svh"
module mseq_core (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // microinstruction fields
  input wire logic [2:0] nextAddrSourceSelect,
  input wire logic [2:0] stackOpSelect,
  input wire logic [2:0] loopRegOpSelect,
  input wire logic condInN,
  input wire logic counterAdvance,
  input wire logic [`MSEQ_AW-1:0] branchAddrPortA,
  input wire logic [`MSEQ_AW-1:0] branchAddrPortB,
  // register bus
  input wire logic [`MSEQ_AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`MSEQ_AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // next address and loop zero flag
  output logic [`MSEQ_AW-1:0] nextAddr,
  output logic loopZero
);
  logic condN_ff;
  logic advance_ff;
  logic [`MSEQ_AW-1:0] nextAddr_ff;
  logic [`MSEQ_AW-1:0] mpc_ff;
  logic [`MSEQ_AW-1:0] loopA_ff;
  logic loopZero_ff;
  logic [`MSEQ_PW-1:0] stackPointer_ff;
  logic [`MSEQ_PW-1:0] readPointer_ff;
  logic [`MSEQ_AW-1:0] stackTop;
  logic [`MSEQ_AW-1:0] loopLoadValue;
  logic [`MSEQ_AW-1:0] nxt_nextAddr;
  logic [`MSEQ_AW-1:0] nxt_loopA;
  logic doPush;
  logic doPop;
  logic doClear;
  logic zeroHit;
  logic [`MSEQ_AW-1:0] nxt_mpc;
  logic [`MSEQ_PW-1:0] nxt_stackPointer;
  logic [`MSEQ_PW-1:0] nxt_readPointer;
  logic [`MSEQ_PW-1:0] stackRdAddr;
  logic stackWrEn;
  mseq_pkg::mseq_nasrc_t naSrc;

  assign nextAddr = nextAddr_ff;
  assign loopZero = loopZero_ff;

  function automatic logic [`MSEQ_PW-1:0] ptrStep(input logic [`MSEQ_PW-1:0] p,
                                                input logic up);
    ptrStep = up ? p + `MSEQ_PW'(1) : p - `MSEQ_PW'(1);
  endfunction

  // condition pipelined one instruction
  always_ff @(posedge clk) begin
    if (reset) begin
      condN_ff <= 1'b1;
    end else begin
      condN_ff <= condInN;
    end
  end

  // advance control pipelined one instruction
  always_ff @(posedge clk) begin
    if (reset) begin
      advance_ff <= 1'b1;
    end else begin
      advance_ff <= counterAdvance;
    end
  end

  // loop register
  always_comb begin
    nxt_loopA = loopA_ff;
    zeroHit = 1'b0;
    unique case (loopRegOpSelect)
      `MSEQ_RO_LOAD: nxt_loopA = loopLoadValue;
      `MSEQ_RO_DEC: begin
        nxt_loopA = loopA_ff - `MSEQ_ONE;
        zeroHit = (nxt_loopA == '0);
      end
      default: nxt_loopA = loopA_ff;
    endcase
  end

  // next-address decision
  always_comb begin
    naSrc = mseq_pkg::NA_CONT;
    doPush = 1'b0;
    doPop = 1'b0;
    doClear = 1'b0;
    unique case (stackOpSelect)
      `MSEQ_SO_RESET: begin
        naSrc = mseq_pkg::NA_ZERO;
        doClear = 1'b1;
      end
      `MSEQ_SO_CLEAR: begin
        doClear = 1'b1;
        naSrc = condN_ff ? mseq_pkg::NA_CONT : mseq_pkg::NA_BRA;
      end
      `MSEQ_SO_LOOP: begin
        if (condN_ff && nextAddrSourceSelect == `MSEQ_NA_STACKSEL) begin
          naSrc = mseq_pkg::NA_BRA;
          doPop = 1'b1;
        end else if (zeroHit) begin
          naSrc = mseq_pkg::NA_CONT;
          doPop = 1'b1;
        end else begin
          naSrc = mseq_pkg::NA_BRSTACK;
        end
      end
      `MSEQ_SO_RET: begin
        if (!condN_ff) begin
          naSrc = mseq_pkg::NA_BRSTACK;
          doPop = 1'b1;
        end
      end
      `MSEQ_SO_PUSH: begin
        doPush = 1'b1;
      end
      `MSEQ_SO_CCALL: begin
        if (!condN_ff) begin
          naSrc = mseq_pkg::NA_BRA;
          doPush = 1'b1;
        end
      end
      `MSEQ_SO_CALL: begin
        doPush = 1'b1;
        if (nextAddrSourceSelect == `MSEQ_NA_TWOWAY) begin
          naSrc = condN_ff ? mseq_pkg::NA_BRB : mseq_pkg::NA_BRA;
        end else begin
          naSrc = mseq_pkg::NA_BRA;
        end
      end
      default: begin
        // unlisted stack code continues
        naSrc = mseq_pkg::NA_CONT;
      end
    endcase
  end

  // continue takes the counter, which already holds the step
  always_comb begin
    nxt_nextAddr = mpc_ff;
    unique case (naSrc)
      mseq_pkg::NA_BRSTACK: nxt_nextAddr = stackTop;
      mseq_pkg::NA_BRA: nxt_nextAddr = branchAddrPortA;
      mseq_pkg::NA_BRB: nxt_nextAddr = branchAddrPortB;
      mseq_pkg::NA_ZERO: nxt_nextAddr = '0;
      mseq_pkg::NA_CONT: nxt_nextAddr = mpc_ff;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      nextAddr_ff <= '0;
    end else begin
      nextAddr_ff <= nxt_nextAddr;
    end
  end

  // microprogram counter
  always_comb begin
    if (advance_ff) begin
      nxt_mpc = nxt_nextAddr + `MSEQ_ONE;
    end else begin
      nxt_mpc = nxt_nextAddr;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mpc_ff <= '0;
    end else begin
      mpc_ff <= nxt_mpc;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      loopA_ff <= '0;
    end else begin
      loopA_ff <= nxt_loopA;
    end
  end

  // zero flag pulses for one cycle after the last decrement
  always_ff @(posedge clk) begin
    if (reset) begin
      loopZero_ff <= 1'b0;
    end else begin
      loopZero_ff <= zeroHit;
    end
  end

  // pointers; stack pointer marks next free slot, read pointer the top
  always_comb begin
    nxt_stackPointer = stackPointer_ff;
    nxt_readPointer = readPointer_ff;
    if (doClear) begin
      nxt_stackPointer = '0;
      nxt_readPointer = '0;
    end else if (doPush) begin
      nxt_stackPointer = ptrStep(stackPointer_ff, 1'b1);
      nxt_readPointer = stackPointer_ff;
    end else if (doPop) begin
      nxt_stackPointer = ptrStep(stackPointer_ff, 1'b0);
      nxt_readPointer = ptrStep(readPointer_ff, 1'b0);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      stackPointer_ff <= '0;
      readPointer_ff <= '0;
    end else begin
      stackPointer_ff <= nxt_stackPointer;
      readPointer_ff <= nxt_readPointer;
    end
  end

  // read address follows the top that the next cycle will need
  always_comb begin
    stackRdAddr = readPointer_ff;
    if (doPush) begin
      stackRdAddr = stackPointer_ff;
    end else if (doPop) begin
      stackRdAddr = ptrStep(readPointer_ff, 1'b0);
    end
  end

  // no push lands while reset holds
  assign stackWrEn = doPush && !reset;

  // pushed word is the counter value before this edge
  mseq_stack_mem u_stack (
    .clk(clk),
    .wrEn(stackWrEn),
    .wrAddr(stackPointer_ff),
    .wrData(mpc_ff),
    .rdAddr(stackRdAddr),
    .rdData(stackTop)
  );

  mseq_axil u_regs (
    .clk(clk),
    .reset(reset),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .loopLoadValue(loopLoadValue),
    .statusY(nextAddr_ff),
    .statusLoop(loopA_ff),
    .statusSp(stackPointer_ff),
    .statusRp(readPointer_ff)
  );
endmodule

// ===== src/mseq_params.svh
// constants of the microsequencer next-address block
`ifndef MSEQ_PARAMS_SVH
`define MSEQ_PARAMS_SVH
`define MSEQ_AW 16
`define MSEQ_DEPTH 16
`define MSEQ_PW 4
`define MSEQ_AXI_AW 4
`define MSEQ_ONE 16'h0001
// next-address source select codes
`define MSEQ_NA_STACKSEL 3'h0
`define MSEQ_NA_RET 3'h2
`define MSEQ_NA_TWOWAY 3'h4
`define MSEQ_NA_CONT 3'h6
// stack operation codes
`define MSEQ_SO_RESET 3'h0
`define MSEQ_SO_CLEAR 3'h1
`define MSEQ_SO_LOOP 3'h2
`define MSEQ_SO_RET 3'h3
`define MSEQ_SO_PUSH 3'h4
`define MSEQ_SO_CCALL 3'h5
`define MSEQ_SO_CALL 3'h6
// loop register operation codes
`define MSEQ_RO_HOLD 3'h0
`define MSEQ_RO_DEC 3'h1
`define MSEQ_RO_LOAD 3'h2
// register map (byte addresses)
`define MSEQ_REG_CTRL 4'h0
`define MSEQ_REG_STAT 4'h4
`define MSEQ_REG_LOOP 4'h8
`define MSEQ_REG_PTR 4'hC
`define MSEQ_RESP_OK 2'h0
`define MSEQ_RESP_ERR 2'h2
`endif

// ===== src/mseq_pkg.sv
// types of the microsequencer next-address block
package mseq_pkg;
  typedef enum logic [2:0] {
    NA_BRSTACK, NA_CONT, NA_BRA, NA_BRB, NA_ZERO
  } mseq_nasrc_t;
endpackage

// ===== src/mseq_stack_mem.sv
// return-address stack memory with registered read data
`timescale 1ns/1ps
`include "mseq_params.svh"
module mseq_stack_mem (
  // clock
  input wire logic clk,
  // write port
  input wire logic wrEn,
  input wire logic [`MSEQ_PW-1:0] wrAddr,
  input wire logic [`MSEQ_AW-1:0] wrData,
  // read port
  input wire logic [`MSEQ_PW-1:0] rdAddr,
  output logic [`MSEQ_AW-1:0] rdData
);
  logic [`MSEQ_AW-1:0] mem [`MSEQ_DEPTH];

  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  // write-through so a fresh push reads back at once
  always_ff @(posedge clk) begin
    if (wrEn && wrAddr == rdAddr) begin
      rdData <= wrData;
    end else begin
      rdData <= mem[rdAddr];
    end
  end
endmodule

// ===== tb/mseq_core_props.sv
// assertions on the sequencer core next-address ports
`timescale 1ns/1ps
module mseq_core_props (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // microinstruction fields
  input wire logic [2:0] nextAddrSourceSelect,
  input wire logic [2:0] stackOpSelect,
  input wire logic [2:0] loopRegOpSelect,
  input wire logic condInN,
  input wire logic counterAdvance,
  input wire logic [15:0] branchAddrPortA,
  input wire logic [15:0] branchAddrPortB,
  // outputs
  input wire logic [15:0] nextAddr,
  input wire logic loopZero
);
  logic c_ff, adv_ff, adv2_ff, rst_ff;
  wire [2:0] sel = nextAddrSourceSelect;
  wire [2:0] so = stackOpSelect;
  wire [15:0] pa = branchAddrPortA;
  wire [15:0] y = nextAddr;
  wire lp = sel == 3'h0 && so == 3'h2 && loopRegOpSelect == 3'h1;
  // counter value now held: next address plus the advance used
  wire [15:0] mpcM = rst_ff ? 16'h0 : y + {15'h0, adv2_ff};
  always_ff @(posedge clk) begin
    c_ff <= reset | condInN;
    adv_ff <= reset | counterAdvance;
    adv2_ff <= reset | adv_ff;
    rst_ff <= reset;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  AST_RST_LOW: assert property (so == 3'h0 |=> y == 16'h0)
    else $error("next address not low");
  AST_CLR_BRA: assert property (so == 3'h1 && !c_ff |=> y == $past(pa))
    else $error("clear did not branch to port a");
  AST_PUSH: assert property (sel == 3'h6 && so == 3'h4 && c_ff |=> y == $past(mpcM))
    else $error("push did not continue");
  AST_LOOP_EXIT: assert property (lp && c_ff |=> y == $past(pa))
    else $error("loop exit not to port a");
  AST_LOOP_END: assert property (lp && !c_ff |=> !loopZero || y == $past(mpcM))
    else $error("loop end did not continue");
  AST_CALL: assert property (sel == 3'h0 && so == 3'h6 && c_ff |=> y == $past(pa))
    else $error("call not to port a");
  AST_CCALL: assert property (sel == 3'h6 && so == 3'h5 |=>
    y == ($past(c_ff) ? $past(mpcM) : $past(pa))) else $error("conditional call wrong");
  AST_TWOWAY: assert property (sel == 3'h4 && so == 3'h6 |=>
    y == ($past(c_ff) ? $past(branchAddrPortB) : $past(pa))) else $error("two-way call wrong");
  AST_RET_CONT: assert property (sel == 3'h2 && so == 3'h3 && c_ff |=> y == $past(mpcM))
    else $error("return did not continue");
endmodule
bind mseq_core mseq_core_props mseq_core_props_inst (.*);

// ===== tb/mseq_core_tb_top.sv
// self-checking bench for the sequencer core
`timescale 1ns/1ps
module mseq_core_tb_top;
  logic clk, reset, status, inc, cond, chkOn, loopZero;
  logic [2:0] sel, so, roReq, ro;
  logic [15:0] pa, pb, y, chkExp;
  logic [3:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rs;
  int nErrors = 0;
  int checked = 0;
  int cyc = 0;
  mseq_ctrl_model mseq_ctrl_model_inst (.stackOpReq(so), .loopRegReq(roReq), .statusIn(status),
    .loopRegOut(ro), .condOut(cond));
  mseq_core mseq_core_inst (.clk(clk), .reset(reset), .nextAddrSourceSelect(sel),
    .stackOpSelect(so), .loopRegOpSelect(ro), .condInN(cond), .counterAdvance(inc),
    .branchAddrPortA(pa), .branchAddrPortB(pb), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .nextAddr(y),
    .loopZero(loopZero));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      nErrors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic printVerdict();
    $display("checks %0d errors %0d", checked, nErrors);
    if (nErrors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      nErrors++;
      printVerdict();
    end
  end
  // next address of the last instruction, once settled
  always @(negedge clk) begin
    if (chkOn) begin
      chk("nextAddr", {16'h0, chkExp}, {16'h0, y});
      chkOn = 1'b0;
    end
  end
  task automatic step(input logic [2:0] s, input logic [2:0] o, input logic [2:0] r,
      input logic st, input logic in, input logic [15:0] a, input logic [15:0] b,
      input logic [15:0] e);
    sel <= s;
    so <= o;
    roReq <= r;
    status <= st;
    inc <= in;
    pa <= a;
    pb <= b;
    @(posedge clk);
    chkExp <= e;
    chkOn <= 1'b1;
  endtask
  task automatic idle();
    sel <= 3'h6;
    so <= 3'h7;
    roReq <= 3'h0;
    status <= 1'b1;
    inc <= 1'b1;
  endtask
  task automatic axw(input logic [3:0] ad, input logic [31:0] d);
    awaddr <= ad;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (awvalid && !awready || wvalid && !wready);
    bready <= 1'b1;
    do @(posedge clk); while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [3:0] ad);
    araddr <= ad;
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clk); while (!rvalid);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic testLoop(input logic [15:0] n, input logic ex);
    axw(4'h8, {16'h0, n});
    chk("bresp", 32'h0, {30'h0, rs});
    axr(4'h0);
    chk("loopLoad", {16'h0, n}, rd);
    step(3'h6, 3'h0, 3'h0, 1'b1, 1'b1, 16'h0, 16'h0, 16'h0);
    step(3'h6, 3'h4, 3'h2, 1'b1, 1'b1, 16'h0, 16'h0, 16'h1);
    step(3'h6, 3'h7, 3'h0, ex, 1'b1, 16'h0, 16'h0, 16'h2);
    step(3'h0, 3'h2, 3'h1, 1'b0, 1'b1, 16'h25, 16'h0, ex ? 16'h25 : 16'h1);
    if (!ex) step(3'h0, 3'h2, 3'h1, 1'b0, 1'b1, 16'h25, 16'h0, 16'h2);
    idle();
    @(negedge clk);
    chk("loopZero", {31'h0, !ex}, {31'h0, loopZero});
    @(posedge clk);
    axr(4'hC);
    chk("stackPointer", 32'h0, {28'h0, rd[3:0]});
    axr(4'h8);
    chk("loopA", {16'h0, ex ? n - 16'h1 : 16'h0}, rd);
    $display("test loop exit %0d done", ex);
  endtask
  task automatic testCalls();
    step(3'h6, 3'h0, 3'h0, 1'b1, 1'b1, 16'h0, 16'h0, 16'h0);
    step(3'h0, 3'h6, 3'h0, 1'b1, 1'b1, 16'h30, 16'h0, 16'h30);
    step(3'h6, 3'h5, 3'h0, 1'b0, 1'b0, 16'h20, 16'h0, 16'h31);
    step(3'h6, 3'h5, 3'h0, 1'b1, 1'b1, 16'h20, 16'h0, 16'h20);
    step(3'h4, 3'h6, 3'h0, 1'b0, 1'b1, 16'h40, 16'h50, 16'h50);
    step(3'h4, 3'h6, 3'h0, 1'b0, 1'b1, 16'h40, 16'h50, 16'h40);
    step(3'h2, 3'h3, 3'h0, 1'b1, 1'b1, 16'h0, 16'h0, 16'h51);
    step(3'h2, 3'h3, 3'h0, 1'b0, 1'b1, 16'h0, 16'h0, 16'h52);
    step(3'h2, 3'h3, 3'h0, 1'b0, 1'b1, 16'h0, 16'h0, 16'h20);
    step(3'h2, 3'h3, 3'h0, 1'b0, 1'b0, 16'h0, 16'h0, 16'h32);
    step(3'h6, 3'h1, 3'h0, 1'b1, 1'b1, 16'h77, 16'h0, 16'h77);
    idle();
    axr(4'hC);
    chk("stackPointer", 32'h0, {28'h0, rd[3:0]});
    axr(4'h6);
    chk("rresp", 32'h2, {30'h0, rs});
    $display("test calls done");
  endtask
  initial begin
    reset = 1'b1;
    {sel, so, roReq, status, inc, pa, pb} = {3'h6, 3'h7, 3'h0, 2'h3, 32'h0};
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready, chkOn} = 46'h0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    testLoop(16'h2, 1'b0);
    testLoop(16'h5, 1'b1);
    testCalls();
    printVerdict();
  end
endmodule

// ===== tb/mseq_ctrl_model.sv
// controller side: register-op field and status condition
`timescale 1ns/1ps
module mseq_ctrl_model (
  // from bench
  input wire logic [2:0] stackOpReq,
  input wire logic [2:0] loopRegReq,
  input wire logic statusIn,
  // to sequencer
  output logic [2:0] loopRegOut,
  output logic condOut
);
  // no register change on call, return or clear
  assign loopRegOut = (stackOpReq inside {3'h1, 3'h3, 3'h5, 3'h6}) ? 3'h0 : loopRegReq;
  assign condOut = statusIn;
endmodule
